// [hdl/rcp_pkg.sv]
// Constants for the remote command parser
package rcp_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_BPS = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int DATA_BITS = 8;
    localparam int FRAME_CHARS = 14;
    localparam int UNIT_CHARS = 6;
    localparam int POS_CODE = 6;
    localparam int POS_ADDR = 7;
    localparam int POS_DATA = 10;
    localparam int POS_CR = 13;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_READ = 8'h52;
    localparam logic [7:0] CH_WRITE = 8'h57;
    localparam logic [7:0] CH_REPLY = 8'h43;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] ADDR_GAIN = 8'h01;
    localparam logic [7:0] ADDR_SHUTTER = 8'h02;
    localparam logic [7:0] ADDR_TRIG_MODE = 8'h04;
    localparam logic [7:0] ADDR_TRIG_POL = 8'h0b;
    localparam logic [7:0] ADDR_OUT_WIDTH = 8'h0d;
    localparam logic [7:0] ADDR_WIN_MODE = 8'h0f;
    localparam logic [7:0] ADDR_START_HI = 8'h10;
    localparam logic [7:0] ADDR_START_LO = 8'h11;
    localparam logic [7:0] ADDR_HEIGHT_HI = 8'h13;
    localparam logic [7:0] ADDR_HEIGHT_LO = 8'h14;
    localparam logic [7:0] ADDR_TOTAL_HI = 8'h15;
    localparam logic [7:0] ADDR_TOTAL_LO = 8'h16;
    localparam logic [7:0] ADDR_SAVE = 8'hff;
    localparam logic [7:0] SAVE_KEY_A = 8'h53;
    localparam logic [7:0] SAVE_KEY_B = 8'h35;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] WIN_MAX = 16'h02ad;
    localparam logic [15:0] TOTAL_BASE = 16'h02c2;
    localparam logic [15:0] RST_TOTAL = 16'h081e;
    typedef enum logic [1:0] {
        RCP_IDLE  = 2'b00,
        RCP_EXEC  = 2'b01,
        RCP_SEND  = 2'b10,
        RCP_WAIT  = 2'b11
    } rcp_state_t;
endpackage : rcp_pkg

// [hdl/rcp_parser.sv]
// Serial ASCII command parser with camera setting registers
`timescale 1ns/1ps
module rcp_parser #(
    // Bit time in clock cycles; the default gives 9600 baud at 25 MHz
    parameter int BIT_LEN = rcp_pkg::BIT_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_rxd,
    output logic             o_txd,
    output logic [7:0]       o_gain,
    output logic [7:0]       o_shutter,
    output logic [7:0]       o_trig_mode,
    output logic [7:0]       o_trig_pol,
    output logic [7:0]       o_out_width,
    output logic [7:0]       o_win_mode,
    output logic [15:0]      o_win_start,
    output logic [15:0]      o_win_height,
    output logic [15:0]      o_total_lines,
    output logic             o_save_req
);
    import rcp_pkg::*;

    // Receiver; bit counter at 25 MHz over 9600 baud
    logic [11:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic        rx_busy;
    logic [7:0]  rx_sh;
    logic        rx_stb;
    logic [7:0]  rx_byte;
    wire         rx_tick = (rx_cnt == 12'(BIT_LEN - 1));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_cnt  <= 12'h000;
            rx_bit  <= 4'h0;
            rx_busy <= 1'b0;
            rx_sh   <= 8'h00;
            rx_stb  <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_stb <= 1'b0;
            if (!rx_busy) begin
                if (!i_rxd) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= 12'(BIT_LEN / 2);
                    rx_bit  <= 4'h0;
                end
            end else if (rx_tick) begin
                rx_cnt <= 12'h000;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && i_rxd) begin
                    rx_busy <= 1'b0; // False start bit
                end else if (rx_bit == 4'(DATA_BITS + 1)) begin
                    rx_busy <= 1'b0;
                    if (i_rxd) begin
                        rx_stb  <= 1'b1;
                        rx_byte <= rx_sh;
                    end
                end else if (rx_bit != 4'h0) begin
                    rx_sh <= {i_rxd, rx_sh[7:1]};
                end
            end else begin
                rx_cnt <= rx_cnt + 12'h001;
            end
        end
    end

    // Frame assembly
    logic [7:0] frm [FRAME_CHARS];
    logic [3:0] pos;
    rcp_state_t state;
    logic [3:0] tx_idx;

    function automatic logic is_dig(input logic [7:0] c);
        return (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction : is_dig

    function automatic logic [9:0] dec3(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c);
        logic [9:0] h;
        logic [9:0] t;
        h = {6'h00, a[3:0]} * 10'd100;
        t = {6'h00, b[3:0]} * 10'd10;
        return h + t + {6'h00, c[3:0]};
    endfunction : dec3

    wire unit_ok = is_dig(frm[0]) && frm[0] == CH_ZERO && frm[1] == CH_ZERO
                && frm[2] == CH_ZERO && frm[3] == CH_ZERO
                && frm[4] == CH_ZERO && frm[5] == CH_ZERO;
    wire digits_ok = is_dig(frm[7]) && is_dig(frm[8]) && is_dig(frm[9])
                  && is_dig(frm[10]) && is_dig(frm[11])
                  && is_dig(frm[12]);
    wire [9:0] addr_dec = dec3(frm[7], frm[8], frm[9]);
    wire [9:0] data_dec = dec3(frm[10], frm[11], frm[12]);
    wire range_ok = (addr_dec < 10'd256) && (data_dec < 10'd256);
    wire is_rd = (frm[POS_CODE] == CH_READ);
    wire is_wr = (frm[POS_CODE] == CH_WRITE);
    wire frame_ok = unit_ok && digits_ok && range_ok
                 && (is_rd || is_wr);
    wire [7:0] addr = addr_dec[7:0];
    wire [7:0] wdata = data_dec[7:0];
    wire do_wr = (state == RCP_EXEC) && frame_ok && is_wr;

    // Window registers and high-byte holding
    logic [7:0] start_hi;
    logic [7:0] height_hi;
    wire [15:0] new_start = {start_hi, wdata};
    wire [15:0] new_height = {height_hi, wdata};
    wire [15:0] st_lim = (new_start > WIN_MAX) ? WIN_MAX : new_start;
    wire [15:0] ht_lim = (new_height > WIN_MAX) ? WIN_MAX : new_height;
    wire [15:0] room_s = WIN_MAX - st_lim;
    wire [15:0] room_c = WIN_MAX - o_win_start;
    wire [15:0] ht_for_start = (o_win_height > room_s) ? room_s
                             : o_win_height;
    wire [15:0] ht_for_height = (ht_lim > room_c) ? room_c : ht_lim;
    // Each height value selects a two-line step
    wire [15:0] next_total = TOTAL_BASE + {o_win_height[14:0], 1'b0}
                           + 16'h0002;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_gain       <= RST_BYTE;
            o_shutter    <= RST_BYTE;
            o_trig_mode  <= RST_BYTE;
            o_trig_pol   <= RST_BYTE;
            o_out_width  <= RST_BYTE;
            o_win_mode   <= RST_BYTE;
            o_win_start  <= RST_WORD;
            o_win_height <= RST_WORD;
            start_hi     <= RST_BYTE;
            height_hi    <= RST_BYTE;
            o_save_req   <= 1'b0;
        end else begin
            o_save_req <= 1'b0;
            if (do_wr) begin
                case (addr)
                    ADDR_GAIN:      o_gain      <= wdata;
                    ADDR_SHUTTER:   o_shutter   <= wdata;
                    ADDR_TRIG_MODE: o_trig_mode <= wdata;
                    ADDR_TRIG_POL:  o_trig_pol  <= wdata;
                    ADDR_OUT_WIDTH: o_out_width <= wdata;
                    ADDR_WIN_MODE:  o_win_mode  <= wdata;
                    ADDR_START_HI:  start_hi    <= wdata;
                    ADDR_START_LO: begin
                        o_win_start  <= st_lim;
                        o_win_height <= ht_for_start;
                    end
                    ADDR_HEIGHT_HI: height_hi   <= wdata;
                    ADDR_HEIGHT_LO: o_win_height <= ht_for_height;
                    ADDR_SAVE: o_save_req <= (wdata == SAVE_KEY_A)
                                          || (wdata == SAVE_KEY_B);
                    default: ; // Unlisted addresses are ignored
                endcase
            end
        end
    end

    // Total follows a window commit one cycle later, so the full-frame
    // reset value stands until the host first sets up a window
    logic win_upd;
    wire  win_commit = do_wr && (addr == ADDR_START_LO
                              || addr == ADDR_HEIGHT_LO);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_total_lines <= RST_TOTAL;
            win_upd       <= 1'b0;
        end else begin
            win_upd <= win_commit;
            if (win_upd) begin
                o_total_lines <= next_total;
            end
        end
    end

    // Read mux
    logic [7:0] rd_val;
    always_comb begin
        case (addr)
            ADDR_GAIN:      rd_val = o_gain;
            ADDR_SHUTTER:   rd_val = o_shutter;
            ADDR_TRIG_MODE: rd_val = o_trig_mode;
            ADDR_TRIG_POL:  rd_val = o_trig_pol;
            ADDR_OUT_WIDTH: rd_val = o_out_width;
            ADDR_WIN_MODE:  rd_val = o_win_mode;
            ADDR_START_HI:  rd_val = o_win_start[15:8];
            ADDR_START_LO:  rd_val = o_win_start[7:0];
            ADDR_HEIGHT_HI: rd_val = o_win_height[15:8];
            ADDR_HEIGHT_LO: rd_val = o_win_height[7:0];
            ADDR_TOTAL_HI:  rd_val = o_total_lines[15:8];
            ADDR_TOTAL_LO:  rd_val = o_total_lines[7:0];
            default:        rd_val = 8'h00;
        endcase
    end

    // Reply value in decimal digits
    wire [7:0] d_hund = 8'(rd_val / 8'd100);
    wire [7:0] d_tens = 8'((rd_val % 8'd100) / 8'd10);
    wire [7:0] d_ones = 8'(rd_val % 8'd10);

    // Transmitter
    logic [11:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic        tx_busy;
    wire         tx_tick = (tx_cnt == 12'(BIT_LEN - 1));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state  <= RCP_IDLE;
            pos    <= 4'h0;
            tx_idx <= 4'h0;
            tx_cnt <= 12'h000;
            tx_bit <= 4'h0;
            tx_sh  <= 10'h3ff;
            tx_busy <= 1'b0;
            for (int i = 0; i < FRAME_CHARS; i++) begin
                frm[i] <= 8'h00;
            end
        end else begin
            case (state)
                RCP_IDLE: begin
                    if (rx_stb) begin
                        frm[pos] <= rx_byte;
                        if (pos == 4'(POS_CR)) begin
                            pos <= 4'h0;
                            if (rx_byte == CH_CR) begin
                                state <= RCP_EXEC;
                            end
                        end else if (rx_byte == CH_CR) begin
                            pos <= 4'h0; // Short frame: resync
                        end else begin
                            pos <= pos + 4'h1;
                        end
                    end
                end
                RCP_EXEC: begin
                    if (frame_ok && is_rd) begin
                        frm[POS_CODE] <= CH_REPLY;
                        frm[POS_DATA] <= CH_ZERO | d_hund;
                        frm[POS_DATA + 1] <= CH_ZERO | d_tens;
                        frm[POS_DATA + 2] <= CH_ZERO | d_ones;
                        tx_idx <= 4'h0;
                        state  <= RCP_SEND;
                    end else begin
                        state <= RCP_IDLE;
                    end
                end
                RCP_SEND: begin
                    tx_sh   <= {1'b1, frm[tx_idx], 1'b0};
                    tx_busy <= 1'b1;
                    tx_bit  <= 4'h0;
                    tx_cnt  <= 12'h000;
                    state   <= RCP_WAIT;
                end
                RCP_WAIT: begin
                    if (tx_tick) begin
                        tx_cnt <= 12'h000;
                        tx_sh  <= {1'b1, tx_sh[9:1]};
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == 4'(DATA_BITS + 1)) begin
                            tx_busy <= 1'b0;
                            if (tx_idx == 4'(POS_CR)) begin
                                state <= RCP_IDLE;
                            end else begin
                                tx_idx <= tx_idx + 4'h1;
                                state  <= RCP_SEND;
                            end
                        end
                    end else begin
                        tx_cnt <= tx_cnt + 12'h001;
                    end
                end
                default: state <= RCP_IDLE;
            endcase
        end
    end

    assign o_txd = tx_busy ? tx_sh[0] : 1'b1;
endmodule : rcp_parser

// [testbench/rcp_parser_chk.sv]
// Port checks for the command parser
`timescale 1ns/1ps
module rcp_parser_chk (
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_rxd,
    input wire logic        o_txd,
    input wire logic [7:0]  o_gain,
    input wire logic [15:0] o_win_start,
    input wire logic [15:0] o_win_height,
    input wire logic [15:0] o_total_lines,
    input wire logic        o_save_req
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_total_from_height: assert property ($changed(o_win_height) |=>
        o_total_lines == 16'h02c2 + 16'h0002 * $past(o_win_height)
        + 16'h0002) else $error("total lines off");
    a_start_in_range: assert property (o_win_start <= 16'h02ad)
        else $error("start above limit");
    a_height_in_range: assert property (o_win_height <= 16'h02ad)
        else $error("height above limit");
    a_window_sum_ok: assert property ($stable(o_win_start)
        && $stable(o_win_height) |-> o_win_start + o_win_height <= 16'h02ad)
        else $error("window sum above limit");
    a_save_one_cycle: assert property (o_save_req |=> !o_save_req)
        else $error("save pulse too long");
    a_save_after_stop: assert property (o_save_req |-> i_rxd)
        else $error("save outside stop bit");
    a_gain_after_stop: assert property ($changed(o_gain) |->
        i_rxd && $past(i_rxd, 2)) else $error("gain change mid frame");
    a_start_bit_held: assert property ($fell(o_txd) |-> !o_txd [*8])
        else $error("start bit too short");
    c_save: cover property (o_save_req);
    c_reply: cover property ($fell(o_txd));
    c_height: cover property ($changed(o_win_height));
endmodule : rcp_parser_chk
bind rcp_parser rcp_parser_chk u_chk (.i_core_clk, .i_nrst, .i_rxd, .o_txd,
    .o_gain, .o_win_start, .o_win_height, .o_total_lines, .o_save_req);

// [testbench/rcp_host_model.sv]
// Host PC model: sends command frames, decodes reply characters
`timescale 1ns/1ps
module rcp_host_model
    import rcp_pkg::*;
#(
    parameter int BIT_LEN = BIT_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_line,
    output logic            o_line,
    output logic [7:0]      o_rx_byte,
    output logic            o_rx_valid
);
    initial begin
        o_line     = 1'b1;
        o_rx_byte  = 8'h00;
        o_rx_valid = 1'b0;
    end
    function automatic logic [7:0] dig(input int v, input int p);
        return CH_ZERO + 8'((v / p) % 10);
    endfunction : dig
    // Line idles high between characters, no flow control
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_core_clk);
            o_line <= f[i];
            repeat (BIT_LEN - 1) @(posedge i_core_clk);
        end
    endtask : send_byte
    // Always fourteen characters, dummy data included on a read
    task automatic send_frame(input logic [7:0] code, input int a,
                              input int d);
        for (int i = 0; i < UNIT_CHARS; i++) send_byte(CH_ZERO);
        send_byte(code);
        for (int p = 100; p > 0; p /= 10) send_byte(dig(a, p));
        for (int p = 100; p > 0; p /= 10) send_byte(dig(d, p));
        send_byte(CH_CR);
    endtask : send_frame
    // Stop bit is not judged; a bad byte shows up at the compare
    always begin : rx_loop
        logic [7:0] r;
        @(posedge i_core_clk);
        if (i_line === 1'b0) begin
            repeat (BIT_LEN / 2) @(posedge i_core_clk);
            for (int i = 0; i < DATA_BITS; i++) begin
                repeat (BIT_LEN) @(posedge i_core_clk);
                r[i] = i_line;
            end
            repeat (BIT_LEN) @(posedge i_core_clk);
            o_rx_byte  <= r;
            o_rx_valid <= 1'b1;
            @(posedge i_core_clk);
            o_rx_valid <= 1'b0;
        end
    end
endmodule : rcp_host_model

// [testbench/tb_rcp_parser.sv]
// Self-checking bench for the command parser
`timescale 1ns/1ps
module tb_rcp_parser;
    import rcp_pkg::*;
    logic        clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        rxd, txd, save, rx_valid;
    logic [7:0]  gain, shut, tmode, tpol, owid, wmode, rx_byte, v;
    logic [15:0] start, height, total;
    logic [7:0]  exp_q[$];
    logic [7:0]  lfsr = 8'h14;
    int          num_errors = 0;
    int          checked = 0;
    int          saves = 0;
    // Short bit time keeps the run brief; the design default is 9600 baud
    localparam int TB_BIT = 16;
    always #20 clk = ~clk;
    rcp_parser #(.BIT_LEN(TB_BIT)) dut (.i_core_clk(clk), .i_nrst(i_nrst),
        .i_rxd(rxd),
        .o_txd(txd), .o_gain(gain), .o_shutter(shut), .o_trig_mode(tmode),
        .o_trig_pol(tpol), .o_out_width(owid), .o_win_mode(wmode),
        .o_win_start(start), .o_win_height(height), .o_total_lines(total),
        .o_save_req(save));
    rcp_host_model #(.BIT_LEN(TB_BIT)) host (.i_core_clk(clk),
        .i_line(txd), .o_line(rxd),
        .o_rx_byte(rx_byte), .o_rx_valid(rx_valid));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    function automatic logic [7:0] dig(input int n, input int p);
        return CH_ZERO + 8'((n / p) % 10);
    endfunction : dig
    // Notes the fourteen characters of one reply frame
    task automatic expect_reply(input int a, input int d);
        for (int i = 0; i < UNIT_CHARS; i++) exp_q.push_back(CH_ZERO);
        exp_q.push_back(CH_REPLY);
        for (int p = 100; p > 0; p /= 10) exp_q.push_back(dig(a, p));
        for (int p = 100; p > 0; p /= 10) exp_q.push_back(dig(d, p));
        exp_q.push_back(CH_CR);
    endtask : expect_reply
    task automatic wait_reply;
        for (int n = 0; n < 16 * 10 * TB_BIT && exp_q.size() > 0; n++) begin
            @(posedge clk);
        end
        check(16'(exp_q.size()), 16'h0000);
    endtask : wait_reply
    // Each reply character is matched against the oldest note
    always @(posedge clk) begin
        if (save === 1'b1) saves++;
        if (rx_valid === 1'b1) begin
            check(rx_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);
        end
    end
    // Budget of thirty frames; the tests need about twenty
    initial begin
        repeat (30 * FRAME_CHARS * 10 * TB_BIT) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        i_nrst <= 1'b1;
        @(posedge clk);
        check({gain, shut}, 16'h0000);
        check({tmode, tpol}, 16'h0000);
        check({owid, wmode}, 16'h0000);
        check(start | height, 16'h0000);
        check(total, 16'h081e);
        $display("reset values done");
        lfsr = lfsr_next(lfsr);
        v = lfsr;
        host.send_frame(CH_WRITE, ADDR_GAIN, v);
        check(gain, v);
        expect_reply(ADDR_GAIN, v);
        host.send_frame(CH_READ, ADDR_GAIN, 8'h7b);
        wait_reply();
        $display("gain write and read done");
        lfsr = lfsr_next(lfsr);
        host.send_frame(CH_WRITE, ADDR_SHUTTER, lfsr);
        check(shut, lfsr);
        lfsr = lfsr_next(lfsr);
        host.send_frame(CH_WRITE, ADDR_TRIG_MODE, lfsr);
        check(tmode, lfsr);
        lfsr = lfsr_next(lfsr);
        host.send_frame(CH_WRITE, ADDR_TRIG_POL, lfsr);
        check(tpol, lfsr);
        lfsr = lfsr_next(lfsr);
        host.send_frame(CH_WRITE, ADDR_OUT_WIDTH, lfsr);
        check(owid, lfsr);
        $display("settings writes done");
        host.send_frame(CH_WRITE, ADDR_WIN_MODE, 8'h01);
        check(wmode, 16'h0001);
        host.send_frame(CH_WRITE, ADDR_HEIGHT_HI, 8'h01);
        check(height, 16'h0000);
        check(total, 16'h081e);
        host.send_frame(CH_WRITE, ADDR_HEIGHT_LO, 8'h64);
        check(height, 16'h0164);
        check(total, 16'h058c);
        host.send_frame(CH_WRITE, ADDR_START_HI, 8'h01);
        host.send_frame(CH_WRITE, ADDR_START_LO, 8'hc8);
        check(start, 16'h01c8);
        check(height, 16'h00e5);
        check(total, 16'h048e);
        host.send_frame(CH_WRITE, ADDR_START_HI, 8'h03);
        host.send_frame(CH_WRITE, ADDR_START_LO, 8'h00);
        check(start, 16'h02ad);
        check(height, 16'h0000);
        check(total, 16'h02c4);
        expect_reply(ADDR_TOTAL_LO, 8'hc4);
        host.send_frame(CH_READ, ADDR_TOTAL_LO, 8'h00);
        wait_reply();
        $display("window done");
        host.send_frame(CH_REPLY, ADDR_GAIN, 8'h07);
        check(gain, v);
        $display("bad code done");
        host.send_frame(CH_WRITE, ADDR_SAVE, 8'h53);
        check(16'(saves), 16'h0001);
        host.send_frame(CH_WRITE, ADDR_SAVE, 8'h35);
        check(16'(saves), 16'h0002);
        $display("save done");
        final_report();
    end
endmodule : tb_rcp_parser
